/* File: design/i2c_slave_with_reset_run.sv */
// Two-wire slave port with command pointer, reset pin gating and reset-run
`timescale 1ns/1ns
`default_nettype none
module i2c_slave_with_reset_run #(
    parameter int RR_PERIODS = i2c_rr_pkg::RR_TIMEOUT_PERIODS
) (
    // System clock and reset
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    // PWM clock, times the reset-run window
    input  wire logic       pwm_clk_i,
    // Serial bus pins
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    // Device pins
    input  wire logic       reset_pin_n_i,
    input  wire logic       address_select_i,
    // Register port towards the rest of the device
    output logic      [7:0] reg_addr_o,
    output logic      [7:0] reg_wdata_o,
    output logic            reg_we_o,
    output logic            reg_re_o,
    input  wire logic [7:0] reg_rdata_i,
    // Device state
    output logic      [7:0] cfg_o,
    output logic            run_o,
    output logic            regs_reset_o,
    output logic            ramp_up_start_o
);

    // Resolve the own address from how the select pin behaved
    function automatic logic [6:0] own_address(input logic hi, input logic lo,
                                               input logic off_scl);
        logic [6:0] a;
        a = i2c_rr_pkg::ADDR_FIXED;
        if (hi && lo) begin
            a[i2c_rr_pkg::ADDR_A7_POS] = 1'b1;          // pin follows a bus line
            a[i2c_rr_pkg::ADDR_A3_POS] = off_scl;       // follows data, not clock
        end else begin
            a[i2c_rr_pkg::ADDR_A3_POS] = hi;            // tied to supply or ground
        end
        return a;
    endfunction

    initial begin
        if (RR_PERIODS < 2) $error("RR_PERIODS must be at least 2");
    end

    // Synchronised pins: scl, sda, reset pin, select pin
    logic [3:0] pins_s;
    logic       scl_s;
    logic       sda_s;
    logic       rst_n_s;
    logic       asel_s;
    logic       scl_d;
    logic       sda_d;
    logic       rst_n_d;
    logic       done_s;
    logic       done_d;
    logic       rr_done;

    sync2 #(.WIDTH(4)) u_pin_sync (
        .clk_i (mclk_i),
        .rst_i (rst_i),
        .d_i   ({scl_i, sda_i, reset_pin_n_i, address_select_i}),
        .q_o   (pins_s)
    );

    sync2 #(.WIDTH(1)) u_done_sync (
        .clk_i (mclk_i),
        .rst_i (rst_i),
        .d_i   (rr_done),
        .q_o   (done_s)
    );

    assign scl_s   = pins_s[3];
    assign sda_s   = pins_s[2];
    assign rst_n_s = pins_s[1];
    assign asel_s  = pins_s[0];

    // Previous samples for edge detection
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_d   <= 1'b0;
            sda_d   <= 1'b0;
            rst_n_d <= 1'b0;
            done_d  <= 1'b0;
        end else begin
            scl_d   <= scl_s;
            sda_d   <= sda_s;
            rst_n_d <= rst_n_s;
            done_d  <= done_s;
        end
    end

    // Bus events
    logic bus_en;
    logic start_c;
    logic stop_c;
    logic scl_rise;
    logic scl_fall;
    logic rst_rise;
    logic rst_fall;
    logic done_rise;

    assign bus_en    = rst_n_s;                                     // [R3]
    assign start_c   = scl_s && scl_d && sda_d && !sda_s;           // [R13]
    assign stop_c    = scl_s && scl_d && !sda_d && sda_s;           // [R13]
    assign scl_rise  = scl_s && !scl_d;
    assign scl_fall  = !scl_s && scl_d;
    assign rst_rise  = rst_n_s && !rst_n_d;
    assign rst_fall  = !rst_n_s && rst_n_d;
    assign done_rise = done_s && !done_d;

    // Serial engine state
    i2c_rr_pkg::slave_state_e state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] shift_reg, shift_next;
    logic       oe_reg, oe_next;
    logic       rw_reg, rw_next;
    logic       first_reg, first_next;
    logic [7:0] ptr_reg, ptr_next;
    logic [7:0] addr_reg, addr_next;
    logic [7:0] wdata_reg, wdata_next;
    logic       we_reg, we_next;
    logic       re_reg, re_next;
    logic       hi_reg, hi_next;
    logic       lo_reg, lo_next;
    logic       off_scl_reg, off_scl_next;

    // Configuration and reset-run state
    logic [7:0] cfg_reg, cfg_next;
    logic       pend_reg, pend_next;
    logic       regrst_reg, regrst_next;
    logic       ramp_reg, ramp_next;

    logic       live;
    logic       addr_match;
    logic       addr_ack;
    logic       rx_done;
    logic [7:0] tx_byte;

    assign live       = bus_en && !start_c && !stop_c;
    assign addr_match = shift_reg[7:1] == own_address(hi_reg, lo_reg, off_scl_reg); // [R16]
    assign addr_ack   = live && state_reg == i2c_rr_pkg::ST_ADDR && scl_fall
                        && cnt_reg == i2c_rr_pkg::BYTE_BITS && addr_match;
    assign rx_done    = live && state_reg == i2c_rr_pkg::ST_RX && scl_fall
                        && cnt_reg == i2c_rr_pkg::BYTE_BITS;
    assign tx_byte    = (ptr_reg == i2c_rr_pkg::CFG_ADDR) ? cfg_reg : reg_rdata_i;

    // Next state of the serial engine
    always_comb begin
        state_next   = state_reg;
        cnt_next     = cnt_reg;
        shift_next   = shift_reg;
        oe_next      = oe_reg;
        rw_next      = rw_reg;
        first_next   = first_reg;
        ptr_next     = ptr_reg;
        wdata_next   = wdata_reg;
        we_next      = 1'b0;
        re_next      = 1'b0;
        hi_next      = hi_reg;
        lo_next      = lo_reg;
        off_scl_next = off_scl_reg;
        if (state_reg == i2c_rr_pkg::ST_ADDR) begin
            hi_next      = hi_reg | asel_s;             // [R25]
            lo_next      = lo_reg | !asel_s;
            off_scl_next = off_scl_reg | (asel_s != scl_s);
        end
        if (!bus_en) begin
            state_next = i2c_rr_pkg::ST_IDLE;           // [R1]
            oe_next    = 1'b0;                          // [R3]
        end else if (start_c) begin
            state_next   = i2c_rr_pkg::ST_ADDR;         // [R18]
            cnt_next     = '0;
            oe_next      = 1'b0;
            hi_next      = asel_s;
            lo_next      = !asel_s;
            off_scl_next = 1'b0;
        end else if (stop_c) begin
            state_next = i2c_rr_pkg::ST_IDLE;           // [R12]
            oe_next    = 1'b0;
        end else begin
            case (state_reg)
                i2c_rr_pkg::ST_IDLE: begin
                    oe_next = 1'b0;
                end
                i2c_rr_pkg::ST_ADDR: begin
                    if (scl_rise) begin                 // [R14]
                        shift_next = {shift_reg[6:0], sda_s};
                        cnt_next   = cnt_reg + 4'h1;
                    end else if (scl_fall && cnt_reg == i2c_rr_pkg::BYTE_BITS) begin
                        if (addr_match) begin
                            state_next = i2c_rr_pkg::ST_ACK_ADDR;
                            oe_next    = 1'b1;          // [R15]
                            rw_next    = shift_reg[0];  // [R17]
                        end else begin
                            state_next = i2c_rr_pkg::ST_IDLE;
                        end
                    end
                end
                i2c_rr_pkg::ST_ACK_ADDR, i2c_rr_pkg::ST_MACK: begin
                    if (state_reg == i2c_rr_pkg::ST_MACK && scl_rise && sda_s) begin
                        state_next = i2c_rr_pkg::ST_IDLE; // Master declined more data
                    end else if (scl_fall) begin
                        cnt_next = '0;
                        if (rw_reg) begin
                            state_next = i2c_rr_pkg::ST_TX; // [R21]
                            shift_next = tx_byte;
                            oe_next    = !tx_byte[7];
                            re_next    = 1'b1;
                        end else begin
                            state_next = i2c_rr_pkg::ST_RX;
                            oe_next    = 1'b0;
                            first_next = 1'b1;
                        end
                    end
                end
                i2c_rr_pkg::ST_RX: begin
                    if (scl_rise) begin
                        shift_next = {shift_reg[6:0], sda_s};
                        cnt_next   = cnt_reg + 4'h1;
                    end else if (rx_done) begin
                        state_next = i2c_rr_pkg::ST_ACK_RX;
                        oe_next    = 1'b1;              // [R15]
                        if (first_reg) begin
                            ptr_next   = shift_reg;     // [R19]
                            first_next = 1'b0;
                        end else begin
                            wdata_next = shift_reg;     // [R20]
                            we_next    = 1'b1;
                            ptr_next   = ptr_reg + 8'h01; // [R24]
                        end
                    end
                end
                i2c_rr_pkg::ST_ACK_RX: begin
                    if (scl_fall) begin
                        state_next = i2c_rr_pkg::ST_RX;
                        oe_next    = 1'b0;
                        cnt_next   = '0;
                    end
                end
                i2c_rr_pkg::ST_TX: begin
                    if (scl_rise) begin
                        cnt_next = cnt_reg + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_reg == i2c_rr_pkg::BYTE_BITS) begin
                            state_next = i2c_rr_pkg::ST_MACK;
                            oe_next    = 1'b0;          // Master acknowledges
                            ptr_next   = ptr_reg + 8'h01; // [R21]
                        end else begin
                            shift_next = {shift_reg[6:0], 1'b0};
                            oe_next    = !shift_reg[6]; // [R11]
                        end
                    end
                end
                default: begin
                    state_next = i2c_rr_pkg::ST_IDLE;
                    oe_next    = 1'b0;
                end
            endcase
        end
        addr_next = we_next ? ptr_reg : ptr_next;       // Write targets the old pointer
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg   <= i2c_rr_pkg::ST_IDLE;
            cnt_reg     <= '0;
            shift_reg   <= '0;
            oe_reg      <= 1'b0;
            rw_reg      <= 1'b0;
            first_reg   <= 1'b0;
            ptr_reg     <= '0;
            addr_reg    <= '0;
            wdata_reg   <= '0;
            we_reg      <= 1'b0;
            re_reg      <= 1'b0;
            hi_reg      <= 1'b0;
            lo_reg      <= 1'b0;
            off_scl_reg <= 1'b0;
        end else begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            shift_reg   <= shift_next;
            oe_reg      <= oe_next;
            rw_reg      <= rw_next;
            first_reg   <= first_next;
            ptr_reg     <= ptr_next;
            addr_reg    <= addr_next;
            wdata_reg   <= wdata_next;
            we_reg      <= we_next;
            re_reg      <= re_next;
            hi_reg      <= hi_next;
            lo_reg      <= lo_next;
            off_scl_reg <= off_scl_next;
        end
    end

    // Configuration register and reset-run control; hardware events win over writes, acknowledge beats expiry
    always_comb begin
        cfg_next    = cfg_reg;
        pend_next   = pend_reg;
        regrst_next = 1'b0;
        ramp_next   = 1'b0;
        if (rx_done && !first_reg && ptr_reg == i2c_rr_pkg::CFG_ADDR) begin
            cfg_next = shift_reg;                       // [R23]
        end
        if (rst_fall) begin
            pend_next = 1'b0;                           // [R7]
            if (cfg_reg[i2c_rr_pkg::RST_REGS_BIT]) begin
                cfg_next    = i2c_rr_pkg::CFG_RESET;    // [R2]
                regrst_next = 1'b1;
            end
        end
        if (rst_rise && cfg_reg[i2c_rr_pkg::RR_EN_BIT]) begin
            pend_next = 1'b1;                           // [R5]
        end
        if (addr_ack && pend_reg) begin
            pend_next                      = 1'b0;      // [R8]
            cfg_next[i2c_rr_pkg::RR_EN_BIT] = 1'b0;     // [R9]
        end else if (done_rise && pend_reg) begin
            pend_next                      = 1'b0;
            cfg_next[i2c_rr_pkg::RUN_BIT]  = 1'b1;      // [R6]
            ramp_next                      = 1'b1;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_reg    <= i2c_rr_pkg::CFG_RESET;
            pend_reg   <= 1'b0;
            regrst_reg <= 1'b0;
            ramp_reg   <= 1'b0;
        end else begin
            cfg_reg    <= cfg_next;
            pend_reg   <= pend_next;
            regrst_reg <= regrst_next;
            ramp_reg   <= ramp_next;
        end
    end

    rr_timer #(.PERIODS(RR_PERIODS)) u_rr_timer (
        .pwm_clk_i (pwm_clk_i),
        .rst_i     (rst_i),
        .arm_i     (pend_reg),
        .done_o    (rr_done)
    );

    // Outputs; data line only ever pulled low
    assign sda_o           = 1'b0;                      // [R11]
    assign sda_oe_o        = oe_reg;
    assign reg_addr_o      = addr_reg;
    assign reg_wdata_o     = wdata_reg;
    assign reg_we_o        = we_reg;
    assign reg_re_o        = re_reg;
    assign cfg_o           = cfg_reg;
    assign run_o           = cfg_reg[i2c_rr_pkg::RUN_BIT];
    assign regs_reset_o    = regrst_reg;
    assign ramp_up_start_o = ramp_reg;

    // Checks on the system clock domain
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    property p_gate_quiet;
        !bus_en |=> !sda_oe_o;
    endproperty
    a_gate_quiet: assert property (p_gate_quiet) // [R3]
        else $error("data line driven while reset pin low");

    property p_gate_idle;
        !bus_en |=> state_reg == i2c_rr_pkg::ST_IDLE;
    endproperty
    a_gate_idle: assert property (p_gate_idle) // [R1]
        else $error("engine not idle under reset pin");

    property p_start_addr;
        (bus_en && start_c) |=> state_reg == i2c_rr_pkg::ST_ADDR && cnt_reg == 4'h0;
    endproperty
    a_start_addr: assert property (p_start_addr) // [R13]
        else $error("start not followed by address phase");

    property p_ack_own;
        addr_ack |=> sda_oe_o && state_reg == i2c_rr_pkg::ST_ACK_ADDR;
    endproperty
    a_ack_own: assert property (p_ack_own) // [R18]
        else $error("own address not acknowledged");

    property p_foreign_passive;
        (live && state_reg == i2c_rr_pkg::ST_ADDR && scl_fall
            && cnt_reg == i2c_rr_pkg::BYTE_BITS && !addr_match)
            |=> !sda_oe_o [*2];
    endproperty
    a_foreign_passive: assert property (p_foreign_passive) // [R18]
        else $error("foreign address driven");

    property p_oe_clock_low;
        (bus_en && $past(bus_en) && $changed(sda_oe_o)) |-> !$past(scl_s);
    endproperty
    a_oe_clock_low: assert property (p_oe_clock_low) // [R14]
        else $error("data line changed while clock high");

    property p_cmd_store;
        (rx_done && first_reg) |=> ptr_reg == $past(shift_reg) && !reg_we_o;
    endproperty
    a_cmd_store: assert property (p_cmd_store) // [R19]
        else $error("command byte not stored");

    property p_ptr_inc;
        (rx_done && !first_reg) |=> ptr_reg == $past(ptr_reg) + 8'h01
            && reg_we_o && reg_addr_o == $past(ptr_reg);
    endproperty
    a_ptr_inc: assert property (p_ptr_inc) // [R24]
        else $error("pointer not advanced after data byte");

    property p_cancel;
        (addr_ack && pend_reg) |=> !cfg_reg[i2c_rr_pkg::RR_EN_BIT] && !pend_reg && !run_o ##1 !pend_reg;
    endproperty
    a_cancel: assert property (p_cancel) // [R9]
        else $error("reset-run not cancelled by acknowledge");

    property p_expire;
        (done_rise && pend_reg && !addr_ack) |=> run_o && ramp_up_start_o;
    endproperty
    a_expire: assert property (p_expire) // [R6]
        else $error("reset-run expiry did not start run");

    property p_discard;
        rst_fall |=> !pend_reg;
    endproperty
    a_discard: assert property (p_discard) // [R7]
        else $error("short reset pulse kept pending");

    property p_regs_reset;
        (rst_fall && cfg_reg[i2c_rr_pkg::RST_REGS_BIT])
            |=> cfg_reg == i2c_rr_pkg::CFG_RESET && regs_reset_o;
    endproperty
    a_regs_reset: assert property (p_regs_reset) // [R2]
        else $error("registers not restored by reset pin");

    c_addr_ack: cover property (addr_ack);
    c_read_byte: cover property (state_reg == i2c_rr_pkg::ST_MACK ##[1:400] reg_re_o);
    c_expire: cover property (done_rise && pend_reg);
    c_cancel: cover property (addr_ack && pend_reg);

endmodule
`default_nettype wire

/* File: design/i2c_rr_pkg.sv */
// Constants and state types shared by the two-wire slave with reset-run
// What this block and the bus master do
// R1: Reset pin low abandons transfer, returns idle
// R2: Config bit D6 lets reset pin restore defaults
// R3: Reset pin low: bus ignored, data undriven
// R4: Master logic raises one shared-address reset pin
// R5: Reset-run: rising pin starts 128-PWM-period timeout
// R6: Timeout expiry sets run bit, starts ramp-up
// R7: Pin falling before expiry discards the pulse
// R8: Acknowledged own address cancels pending reset-run
// R9: Cancel clears reset-run enable; run stays cleared
// R10: Master sends start and address within 4ms
// R11: Data line open-drain low only; clock input only
// R12: Transfer: start, address, command, data, stop
// R13: Start/stop are data edges while clock high
// R14: One bit per clock; data stable clock-high
// R15: Ninth clock carries acknowledge from receiver
// R16: Address fixed bits plus select-pin chosen A7/A3
// R17: Direction bit low writes, high reads
// R18: Acknowledge own address after start, else passive
// R19: First written byte becomes command pointer
// R20: Data bytes go to pointer, then next registers
// R21: Reads start at stored pointer, then advance
// R22: Multi-master reads use repeated start after pointer
// R23: Run bit is D0 of configuration register 0x10
// R24: Pointer increments per data byte, kept across transfers
// R25: Select pin resolved against live bus activity
package i2c_rr_pkg;

    // Register map held inside this block
    localparam logic [7:0] CFG_ADDR       = 8'h10;
    localparam logic [7:0] CFG_RESET      = 8'h00;
    localparam int         RUN_BIT        = 0;
    localparam int         RR_EN_BIT      = 1;
    localparam int         RST_REGS_BIT   = 6;

    // Slave address layout, 7 bits without the direction bit
    localparam logic [6:0] ADDR_FIXED     = 7'h20;
    localparam int         ADDR_A7_POS    = 6;
    localparam int         ADDR_A3_POS    = 2;

    // Byte framing
    localparam logic [3:0] BYTE_BITS      = 4'h8;

    // Reset-run timeout in PWM clock periods
    localparam int         RR_TIMEOUT_PERIODS = 128;

    // Serial engine states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK_ADDR,
        ST_RX,
        ST_ACK_RX,
        ST_TX,
        ST_MACK
    } slave_state_e;

endpackage

/* File: design/sync2.sv */
// Two flip-flop synchroniser for levels entering a clock domain
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Level in and synchronised level out
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] q_reg;

    initial begin
        if (WIDTH < 1) $error("sync2: WIDTH must be at least 1");
    end

    // First stage feeds only the second stage
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            q_reg    <= '0;
        end else begin
            meta_reg <= d_i;
            q_reg    <= meta_reg;
        end
    end

    assign q_o = q_reg;

endmodule
`default_nettype wire

/* File: design/rr_timer.sv */
// Reset-run timeout counter on the PWM clock
`timescale 1ns/1ns
`default_nettype none
module rr_timer #(
    parameter int PERIODS = i2c_rr_pkg::RR_TIMEOUT_PERIODS
) (
    // PWM clock domain
    input  wire logic pwm_clk_i,
    input  wire logic rst_i,
    // Arm level from the system clock domain
    input  wire logic arm_i,
    // Expiry level, held while still armed
    output logic      done_o
);

    localparam int CW = $clog2(PERIODS + 1);
    localparam logic [CW-1:0] LIMIT = CW'(PERIODS);

    logic          arm_s;
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic          done_reg;
    logic          done_next;

    initial begin
        if (PERIODS < 2) $error("rr_timer: PERIODS must be at least 2");
    end

    sync2 #(.WIDTH(1)) u_arm_sync (
        .clk_i (pwm_clk_i),
        .rst_i (rst_i),
        .d_i   (arm_i),
        .q_o   (arm_s)
    );

    // Count PWM periods while armed; disarming restarts the count
    always_comb begin
        cnt_next  = cnt_reg;
        if (!arm_s) begin
            cnt_next = '0;                              // [R7]
        end else if (cnt_reg != LIMIT) begin
            cnt_next = cnt_reg + CW'(1);                // [R5]
        end
        done_next = arm_s && (cnt_next == LIMIT);
    end

    always_ff @(posedge pwm_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_reg  <= '0;
            done_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            done_reg <= done_next;
        end
    end

    assign done_o = done_reg;

    // Expiry only after the full count of armed periods
    property p_done_after_count;
        @(posedge pwm_clk_i) disable iff (rst_i)
        $rose(done_reg) |-> $past(arm_s) && $past(cnt_reg) == LIMIT - CW'(1);
    endproperty
    a_done_after_count: assert property (p_done_after_count) // [R5]
        else $error("reset-run expiry without full count");

endmodule
`default_nettype wire

/* File: dv/i2c_master_model.sv */
// Bus master model driving the two-wire clock and data lines
`timescale 1ns/1ns
`default_nettype none
module i2c_master_model (
    // Wired data level and master drives
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_pull_o
);
    localparam int Q = 250;
    // Both lines idle high
    initial begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end
    // Start or repeated start: data falls while clock high
    task automatic start();
        sda_pull_o <= 1'b0;
        #Q scl_o <= 1'b1;
        #Q sda_pull_o <= 1'b1;
        #Q scl_o <= 1'b0;
    endtask
    // One bit a clock pulse, data held while clock high
    task automatic bit_x(input logic b, output logic s);
        sda_pull_o <= ~b;
        #Q scl_o <= 1'b1;
        #Q s = sda_i;
        #Q scl_o <= 1'b0;
        #Q;
    endtask
    // MSB first byte plus ninth acknowledge clock
    task automatic xfer(input logic [7:0] d, input logic mk, output logic [7:0] r,
                        output logic ack);
        for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
        bit_x(mk, ack);
    endtask
    // Stop: data rises while clock high
    task automatic stop();
        sda_pull_o <= 1'b1;
        #Q scl_o <= 1'b1;
        #Q sda_pull_o <= 1'b0;
        #Q;
    endtask
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the two-wire slave with reset-run
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic mclk = 1'b0, pwm = 1'b0, rst = 1'b1, pin = 1'b1, oe, pull, scl, we, ack;
    logic asel = 1'b0, sdo, re, rrst;
    logic [7:0] radr, wdat, cfg, rd, waddr, wdata;
    logic run, ramp;
    int failures = 0, samples_checked = 0, cycles = 0, ramps = 0, reads = 0, resets = 0;
    // Open-drain data line, high unless a side pulls it low
    wire logic sda = ~((oe & ~sdo) | pull);
    initial forever #5 mclk = ~mclk;
    initial begin
        #7;
        forever begin
            #62 pwm = ~pwm;
            #63 pwm = ~pwm;
        end
    end
    i2c_master_model m (.sda_i(sda), .scl_o(scl), .sda_pull_o(pull));
    i2c_slave_with_reset_run #(.RR_PERIODS(120)) dut (.mclk_i(mclk), .rst_i(rst),
        .pwm_clk_i(pwm), .scl_i(scl), .sda_i(sda), .sda_o(sdo), .sda_oe_o(oe),
        .reset_pin_n_i(pin), .address_select_i(asel), .reg_addr_o(radr),
        .reg_wdata_o(wdat), .reg_we_o(we), .reg_re_o(re), .reg_rdata_i(~radr), .cfg_o(cfg),
        .run_o(run), .regs_reset_o(rrst), .ramp_up_start_o(ramp));
    // Record writes, ramp pulses and the hang limit
    always @(posedge mclk) begin
        cycles++;
        if (we) {waddr, wdata} = {radr, wdat};
        if (ramp) ramps++;
        if (re) reads++;
        if (rrst) resets++;
        if (cycles == 40000) begin
            failures++;
            finish_test();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tx(input logic [7:0] d, input logic mk);
        m.xfer(d, mk, rd, ack);
    endtask
    task automatic set_pin(input logic v);
        @(posedge mclk);
        pin <= v; // One device, so only this pin is driven to v
    endtask
    task automatic t_write();
        m.start();
        tx(8'h40, 1'b1);
        check(ack, 1'b0);
        tx(8'h10, 1'b1);
        tx(8'h02, 1'b1);
        tx(8'h77, 1'b1);
        m.stop();
        check(cfg, 8'h02);
        check(waddr, 8'h11);
        check(wdata, 8'h77);
        $display("burst write done");
    endtask
    task automatic t_read();
        m.start();
        tx(8'h40, 1'b1);
        tx(8'h20, 1'b1);
        m.start(); // Repeated start keeps the pointer ours
        tx(8'h41, 1'b1);
        check(ack, 1'b0);
        tx(8'hff, 1'b0);
        check(rd, 8'hdf);
        tx(8'hff, 1'b1);
        check(rd, 8'hde);
        m.stop();
        m.start();
        tx(8'h90, 1'b1);
        check(ack, 1'b1);
        m.stop();
        check(8'(reads), 8'h02);
        @(posedge mclk) asel <= 1'b1;
        m.start();
        tx(8'h48, 1'b1);
        check(ack, 1'b0);
        m.stop();
        @(posedge mclk) asel <= 1'b0;
        $display("read and address choices done");
    endtask
    task automatic t_cancel();
        set_pin(1'b0);
        m.start();
        tx(8'h40, 1'b1);
        check(ack, 1'b1);
        m.stop();
        set_pin(1'b1);
        m.start(); // Address sent well inside the timeout
        tx(8'h40, 1'b1);
        check(ack, 1'b0);
        m.stop();
        repeat (130) @(posedge pwm);
        check(cfg, 8'h00);
        $display("gating and cancel done");
    endtask
    task automatic t_runs();
        m.start();
        tx(8'h40, 1'b1);
        tx(8'h10, 1'b1);
        tx(8'h02, 1'b1);
        m.stop();
        set_pin(1'b0);
        repeat (4) @(posedge pwm);
        set_pin(1'b1);
        repeat (60) @(posedge pwm);
        set_pin(1'b0);
        repeat (130) @(posedge pwm);
        check(run, 1'b0);
        set_pin(1'b1);
        repeat (118) @(posedge pwm);
        check(run, 1'b0);
        repeat (8) @(posedge pwm);
        check(cfg, 8'h03);
        check(8'(ramps), 8'h01);
        m.start();
        tx(8'h40, 1'b1);
        tx(8'h10, 1'b1);
        tx(8'h41, 1'b1);
        m.stop();
        set_pin(1'b0);
        repeat (8) @(posedge mclk);
        check(cfg, 8'h00);
        check(8'(resets), 8'h01);
        $display("reset-run expiry and register reset done");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        repeat (10) @(posedge mclk);
        t_write();
        t_read();
        t_cancel();
        t_runs();
        finish_test();
    end
endmodule
`default_nettype wire
